// ==== design/oddc_pin_mode.sv ====
`timescale 1ns/1ps
`default_nettype none
module oddc_pin_mode (
   // Mode setting
   input  wire logic [3:0]              i_pin_mode,
   // Decoded pin control
   output oddc_pkg::oddc_pin_ctrl_t     o_ctrl
);
   import oddc_pkg::*;

   always_comb begin
      o_ctrl = '0;
      case (i_pin_mode)
         // RULE11: external termination
         PIN_EXT_TERM: begin
            o_ctrl.diff_en = 1'b1;
         end
         // RULE12: pull up, differential
         PIN_PULL_UP: begin
            o_ctrl.diff_en = 1'b1;
            o_ctrl.pull_up = 1'b1;
         end
         // RULE12: pull down, differential
         PIN_PULL_DN: begin
            o_ctrl.diff_en   = 1'b1;
            o_ctrl.pull_down = 1'b1;
         end
         // RULE13: positive pin only
         PIN_CMOS_POS: begin
            o_ctrl.pos_cmos_en = 1'b1;
         end
         // RULE9: negative pin only
         PIN_CMOS_NEG: begin
            o_ctrl.neg_cmos_en = 1'b1;
         end
         // RULE10: both pins CMOS
         PIN_CMOS_BOTH: begin
            o_ctrl.pos_cmos_en = 1'b1;
            o_ctrl.neg_cmos_en = 1'b1;
         end
         // Undefined codes fall back to safe differential
         default: begin
            o_ctrl.diff_en = 1'b1;
            o_ctrl.invalid = 1'b1;
         end
      endcase
   end
endmodule // oddc_pin_mode
`default_nettype wire

// ==== design/oddc_pkg.sv ====
// Behaviour
// RULE1: Divider bits 19:16, 15:8, 7:0 come from registers 0x50, 0x51, 0x52.
// RULE2: Misc register bits 7:6 supply divider bits 29 and 28.
// RULE3: Software writes the single-ended strength field as 7.
// RULE4: Coarse delay is the six-bit code times one VCO period.
// RULE5: Fine delay is the two-bit code in delay bits 7:6 times 30 ps.
// RULE6: Misc bit 4 widens fine delay to three bits, 0 to 4 steps; the code forces 4 steps whenever the bit is set.
// RULE7: Software sets supply field: 00 1.8 V, 01 2.5 V, 10 3.3 V.
// RULE8: Driver field picks LVDS, boosted LVDS, CML, HCSL, LVPECL with/without current.
// RULE9: Pin mode 1000 drives CMOS on negative pin only.
// RULE10: Pin mode 1100 drives CMOS on both pins.
// RULE11: Pin mode 0000 is differential with external termination.
// RULE12: Pin mode 0010 pulls up, 0001 pulls down, both stay differential.
// RULE13: Pin mode 0100 drives CMOS on positive pin only.
// RULE14: Divider ratio is used only once all its parts are written.
package oddc_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADDR_DIV_UPPER   = 8'h50;
   localparam logic [7:0] ADDR_DIV_MIDDLE  = 8'h51;
   localparam logic [7:0] ADDR_DIV_LOWER   = 8'h52;
   localparam logic [7:0] ADDR_PHASE_STR   = 8'h53;
   localparam logic [7:0] ADDR_DELAY       = 8'h54;
   localparam logic [7:0] ADDR_SUPPLY_DRV  = 8'h55;
   localparam logic [7:0] ADDR_MISC_PIN    = 8'h57;

   // ****************************************
   // Reset values and readable bit masks
   // ****************************************
   localparam logic [7:0] REG_RESET        = 8'h00;
   localparam logic [7:0] MASK_DIV_UPPER   = 8'h0f;
   localparam logic [7:0] MASK_FULL        = 8'hff;
   localparam logic [7:0] MASK_PHASE_STR   = 8'hc7;
   localparam logic [7:0] MASK_SUPPLY_DRV  = 8'h1f;
   localparam logic [7:0] MASK_MISC_PIN    = 8'hdf;
   localparam logic [7:0] UNMAPPED_READ    = 8'h00;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int DIV_WIDTH         = 30;
   localparam int COARSE_LSB        = 0;
   localparam int COARSE_W          = 6;
   localparam int FINE_LSB          = 6;
   localparam int FINE_W            = 2;
   localparam int FINE_EXT_BIT      = 4;
   localparam int DIV_TOP_LSB       = 6;
   localparam int PIN_MODE_LSB      = 0;
   localparam int PIN_MODE_W        = 4;
   localparam int SUPPLY_LSB        = 3;
   localparam int DRV_LSB           = 0;
   localparam int STRENGTH_LSB      = 0;
   localparam int PHASE_LSB         = 6;

   // ****************************************
   // Timing
   // ****************************************
   localparam int            FINE_STEP_PS    = 30;
   localparam logic [2:0]    FINE_EXT_MAX    = 3'h4;
   localparam int            DIV_PART_COUNT  = 4;

   // ****************************************
   // Encodings
   // ****************************************
   typedef enum logic [2:0] {
      ODDC_DRV_LVDS        = 3'b000,
      ODDC_DRV_LVPECL_CM   = 3'b001,
      ODDC_DRV_CML         = 3'b010,
      ODDC_DRV_HCSL        = 3'b011,
      ODDC_DRV_LVDS_BOOST  = 3'b100,
      ODDC_DRV_LVPECL_NOCM = 3'b101,
      ODDC_DRV_RSVD6       = 3'b110,
      ODDC_DRV_RSVD7       = 3'b111
   } oddc_drv_t;

   localparam logic [3:0] PIN_EXT_TERM  = 4'h0;
   localparam logic [3:0] PIN_PULL_DN   = 4'h1;
   localparam logic [3:0] PIN_PULL_UP   = 4'h2;
   localparam logic [3:0] PIN_CMOS_POS  = 4'h4;
   localparam logic [3:0] PIN_CMOS_NEG  = 4'h8;
   localparam logic [3:0] PIN_CMOS_BOTH = 4'hc;

   typedef struct packed {
      logic diff_en;
      logic pos_cmos_en;
      logic neg_cmos_en;
      logic pull_up;
      logic pull_down;
      logic invalid;
   } oddc_pin_ctrl_t;

   typedef struct packed {
      logic [5:0] coarse_vco;
      logic [2:0] fine_steps;
      logic [7:0] fine_ps;
   } oddc_delay_t;

endpackage

// ==== design/oddc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module oddc_top (
   // Clock and reset
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_reset,
   // Register port from serial configuration logic
   input  wire logic [7:0]              i_reg_addr,
   input  wire logic                    i_reg_wr,
   input  wire logic [7:0]              i_reg_wdata,
   input  wire logic                    i_reg_rd,
   output logic      [7:0]              o_reg_rdata,
   output logic                         o_reg_rvalid,
   // Divider
   output logic [oddc_pkg::DIV_WIDTH-1:0] o_divider_ratio,
   output logic                         o_divider_update,
   // Delay
   output oddc_pkg::oddc_delay_t        o_delay,
   // Driver configuration
   output oddc_pkg::oddc_drv_t          o_driver_standard,
   output logic                         o_driver_invalid,
   output logic      [1:0]              o_output_supply_select,
   output logic      [2:0]              o_se_strength,
   output logic      [1:0]              o_phase_select,
   output oddc_pkg::oddc_pin_ctrl_t     o_pin_ctrl
);
   import oddc_pkg::*;

   // ****************************************
   // Register storage
   // ****************************************
   logic [7:0] div_upper_q;
   logic [7:0] div_middle_q;
   logic [7:0] div_lower_q;
   logic [7:0] phase_str_q;
   logic [7:0] delay_q;
   logic [7:0] supply_drv_q;
   logic [7:0] misc_pin_q;
   logic [DIV_PART_COUNT-1:0] div_written_q;
   logic [DIV_PART_COUNT-1:0] div_written_d;
   logic [DIV_PART_COUNT-1:0] div_hit;
   logic                      div_commit;
   logic [DIV_WIDTH-1:0]      div_next;
   oddc_pin_ctrl_t            pin_ctrl;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic wr_to(input logic [7:0] addr);
      return i_reg_wr && (i_reg_addr == addr);
   endfunction

   function automatic logic [7:0] masked(input logic [7:0] v,
                                         input logic [7:0] m);
      return v & m;
   endfunction

   // Fine delay in ps, steps times step size
   function automatic logic [7:0] fine_to_ps(input logic [2:0] steps);
      logic [7:0] prod;
      prod = 8'(int'(steps) * FINE_STEP_PS);
      return prod;
   endfunction

   // Reserved driver codes are flagged, never remapped
   function automatic logic drv_reserved(input logic [2:0] code);
      return (code == ODDC_DRV_RSVD6) || (code == ODDC_DRV_RSVD7);
   endfunction

   // ****************************************
   // Register writes
   // ****************************************
   // Unmapped offsets are dropped without error
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         div_upper_q  <= REG_RESET;
         div_middle_q <= REG_RESET;
         div_lower_q  <= REG_RESET;
         phase_str_q  <= REG_RESET;
         delay_q      <= REG_RESET;
         supply_drv_q <= REG_RESET;
         misc_pin_q   <= REG_RESET;
      end else begin
         if (wr_to(ADDR_DIV_UPPER))
            div_upper_q <= masked(i_reg_wdata, MASK_DIV_UPPER);
         if (wr_to(ADDR_DIV_MIDDLE))
            div_middle_q <= i_reg_wdata;
         if (wr_to(ADDR_DIV_LOWER))
            div_lower_q <= i_reg_wdata;
         if (wr_to(ADDR_PHASE_STR))
            phase_str_q <= masked(i_reg_wdata, MASK_PHASE_STR);
         if (wr_to(ADDR_DELAY))
            delay_q <= i_reg_wdata;
         if (wr_to(ADDR_SUPPLY_DRV))
            supply_drv_q <= masked(i_reg_wdata, MASK_SUPPLY_DRV);
         if (wr_to(ADDR_MISC_PIN))
            misc_pin_q <= masked(i_reg_wdata, MASK_MISC_PIN);
      end
   end

   // ****************************************
   // Read-back
   // ****************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_reg_rdata  <= UNMAPPED_READ;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         // Same-cycle write shows on the next read only
         if (i_reg_rd) begin
            case (i_reg_addr)
               ADDR_DIV_UPPER:  o_reg_rdata <= div_upper_q;
               ADDR_DIV_MIDDLE: o_reg_rdata <= div_middle_q;
               ADDR_DIV_LOWER:  o_reg_rdata <= div_lower_q;
               ADDR_PHASE_STR:  o_reg_rdata <= phase_str_q;
               ADDR_DELAY:      o_reg_rdata <= delay_q;
               ADDR_SUPPLY_DRV: o_reg_rdata <= supply_drv_q;
               ADDR_MISC_PIN:   o_reg_rdata <= misc_pin_q;
               default:         o_reg_rdata <= UNMAPPED_READ;
            endcase
         end
      end
   end

   // ****************************************
   // Divider assembly
   // ****************************************
   always_comb begin
      div_hit = {wr_to(ADDR_MISC_PIN), wr_to(ADDR_DIV_UPPER),
                 wr_to(ADDR_DIV_MIDDLE), wr_to(ADDR_DIV_LOWER)};
      // RULE14: commit once all parts seen
      div_written_d = div_written_q | div_hit;
      div_commit    = &div_written_d;
      div_next      = '0;
      // RULE1: lower twenty bits
      div_next[19:16] = wr_to(ADDR_DIV_UPPER) ? i_reg_wdata[3:0]
                                              : div_upper_q[3:0];
      div_next[15:8]  = wr_to(ADDR_DIV_MIDDLE) ? i_reg_wdata
                                               : div_middle_q;
      div_next[7:0]   = wr_to(ADDR_DIV_LOWER) ? i_reg_wdata
                                              : div_lower_q;
      // RULE2: top two bits from misc
      div_next[29:28] = wr_to(ADDR_MISC_PIN)
                        ? i_reg_wdata[DIV_TOP_LSB +: 2]
                        : misc_pin_q[DIV_TOP_LSB +: 2];
   end

   // Half-written ratio never reaches the divider
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         div_written_q    <= '0;
         o_divider_ratio  <= '0;
         o_divider_update <= 1'b0;
      end else begin
         o_divider_update <= div_commit;
         if (div_commit) begin
            // RULE14: apply whole ratio
            div_written_q   <= '0;
            o_divider_ratio <= div_next;
         end else begin
            div_written_q <= div_written_d;
         end
      end
   end

   // ****************************************
   // Delay and driver outputs
   // ****************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_delay <= '0;
      end else begin
         // RULE4: coarse VCO periods
         o_delay.coarse_vco <= delay_q[COARSE_LSB +: COARSE_W];
         if (misc_pin_q[FINE_EXT_BIT]) begin
            // RULE6: extension bit forces four steps, delay code ignored
            o_delay.fine_steps <= FINE_EXT_MAX;
            o_delay.fine_ps    <= fine_to_ps(FINE_EXT_MAX);
         end else begin
            // RULE5: two-bit fine steps
            o_delay.fine_steps <= {1'b0, delay_q[FINE_LSB +: FINE_W]};
            o_delay.fine_ps <=
               fine_to_ps({1'b0, delay_q[FINE_LSB +: FINE_W]});
         end
      end
   end

   // ****************************************
   // Pin mode decode
   // ****************************************
   oddc_pin_mode u_pin_mode (
      .i_pin_mode (misc_pin_q[PIN_MODE_LSB +: PIN_MODE_W]),
      .o_ctrl     (pin_ctrl)
   );

   // ****************************************
   // Driver configuration
   // ****************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_driver_standard      <= ODDC_DRV_LVDS;
         o_driver_invalid       <= 1'b0;
         o_output_supply_select <= '0;
         o_se_strength          <= '0;
         o_phase_select         <= '0;
         o_pin_ctrl             <= '0;
      end else begin
         // RULE8: driver standard select
         o_driver_standard <= oddc_drv_t'(supply_drv_q[DRV_LSB +: 3]);
         o_driver_invalid  <= drv_reserved(supply_drv_q[DRV_LSB +: 3]);
         // RULE7: supply passed as programmed
         o_output_supply_select <= supply_drv_q[SUPPLY_LSB +: 2];
         // RULE3: strength passed as programmed
         o_se_strength  <= phase_str_q[STRENGTH_LSB +: 3];
         o_phase_select <= phase_str_q[PHASE_LSB +: 2];
         // RULE9: registered pin control
         o_pin_ctrl <= pin_ctrl;
      end
   end
endmodule // oddc_top
`default_nettype wire

// ==== verif/oddc_chk_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module oddc_chk (
   // Clock, reset, register port
   input wire logic                     i_ref_clk,
   input wire logic                     i_reset,
   input wire logic [7:0]               i_reg_addr,
   input wire logic                     i_reg_wr,
   input wire logic [7:0]               i_reg_wdata,
   input wire logic                     i_reg_rd,
   input wire logic                     o_reg_rvalid,
   // Configuration outputs
   input wire logic [29:0]              o_divider_ratio,
   input wire logic                     o_divider_update,
   input wire oddc_pkg::oddc_delay_t    o_delay,
   input wire logic [2:0]               o_driver_standard,
   input wire logic                     o_driver_invalid,
   input wire oddc_pkg::oddc_pin_ctrl_t o_pin_ctrl
);
   import oddc_pkg::*;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);
   a_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read gave no answer");
   a_coarse_load: assert property ((i_reg_wr && i_reg_addr == 8'h54)
      |-> ##2 o_delay.coarse_vco == $past(i_reg_wdata[5:0], 2))
      else $error("coarse delay not loaded");
   a_fine_ext: assert property ((i_reg_wr && i_reg_addr == 8'h57
      && i_reg_wdata[4]) |-> ##2 o_delay.fine_steps == 3'h4)
      else $error("fine extension not applied");
   a_fine_ps: assert property (
      o_delay.fine_ps == 8'(o_delay.fine_steps) * 8'd30)
      else $error("fine delay not 30 ps steps");
   a_ratio_gap: assert property (o_divider_ratio[27:20] == 8'h00)
      else $error("divider bits 27:20 set");
   a_ratio_hold: assert property (
      !o_divider_update |-> $stable(o_divider_ratio))
      else $error("divider changed without update");
   a_drv_invalid: assert property (
      o_driver_invalid == (o_driver_standard[2:1] == 2'b11))
      else $error("driver invalid flag wrong");
   a_pin_excl: assert property (o_pin_ctrl.diff_en |->
      !(o_pin_ctrl.pos_cmos_en || o_pin_ctrl.neg_cmos_en))
      else $error("differential with cmos drive");
   c_update: cover property (o_divider_update);
   c_cmos_both: cover property (o_pin_ctrl.pos_cmos_en
      && o_pin_ctrl.neg_cmos_en);
   c_fine_max: cover property (o_delay.fine_steps == 3'h4);
endmodule // oddc_chk
bind oddc_top oddc_chk u_chk (.i_ref_clk, .i_reset, .i_reg_addr,
   .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rvalid, .o_divider_ratio,
   .o_divider_update, .o_delay, .o_driver_standard, .o_driver_invalid,
   .o_pin_ctrl);
`default_nettype wire

// ==== verif/oddc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module oddc_host (
   // Clock and read answer
   input  wire logic       i_ref_clk,
   input  wire logic [7:0] i_reg_rdata,
   input  wire logic       i_reg_rvalid,
   // Register requests
   output logic      [7:0] o_reg_addr,
   output logic            o_reg_wr,
   output logic      [7:0] o_reg_wdata,
   output logic            o_reg_rd
);
   initial begin
      o_reg_addr = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_wdata = 8'h00;
      o_reg_rd = 1'b0;
   end
   // Idle lines show inverted junk, never the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      #1;
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(posedge i_ref_clk);
      #1;
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      #1;
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(posedge i_ref_clk);
      #1;
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
      d = i_reg_rvalid ? i_reg_rdata : 8'hxx;
   endtask
endmodule // oddc_host
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   import oddc_pkg::*;
   logic i_ref_clk, i_reset, i_reg_wr, i_reg_rd, o_reg_rvalid;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rd_v;
   logic [29:0] o_divider_ratio;
   logic o_divider_update, o_driver_invalid;
   oddc_delay_t o_delay;
   oddc_drv_t o_driver_standard;
   logic [1:0] o_output_supply_select, o_phase_select;
   logic [2:0] o_se_strength;
   oddc_pin_ctrl_t o_pin_ctrl;
   int err_total, check_count;
   logic [7:0] adr [8] = '{8'h50, 8'h51, 8'h52, 8'h53,
                           8'h54, 8'h55, 8'h56, 8'h57};
   logic [7:0] msk [8] = '{8'h0f, 8'hff, 8'hff, 8'hc7,
                           8'hff, 8'h1f, 8'h00, 8'hdf};
   logic [3:0] pm [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hc, 4'h3};
   logic [5:0] pe [7] = '{6'h20, 6'h22, 6'h24, 6'h10, 6'h08, 6'h18,
                          6'h21};
   oddc_top DUT (.i_ref_clk, .i_reset, .i_reg_addr, .i_reg_wr,
      .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
      .o_divider_ratio, .o_divider_update, .o_delay, .o_driver_standard,
      .o_driver_invalid, .o_output_supply_select, .o_se_strength,
      .o_phase_select, .o_pin_ctrl);
   oddc_host host (.i_ref_clk, .i_reg_rdata(o_reg_rdata),
      .i_reg_rvalid(o_reg_rvalid), .o_reg_addr(i_reg_addr),
      .o_reg_wr(i_reg_wr), .o_reg_wdata(i_reg_wdata),
      .o_reg_rd(i_reg_rd));
   always #5 i_ref_clk = ~i_ref_clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rd_v);
      chk(32'(rd_v), 32'(e));
   endtask
   // Delay, driver and pin outputs trail the write edge by one edge; wrs waits two
   task automatic wrs(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      repeat (2) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #50000;
      err_total++;
      summarize();
   end
   initial begin
      i_ref_clk = 1'b0;
      i_reset = 1'b1;
      err_total = 0;
      check_count = 0;
      repeat (8) @(posedge i_ref_clk);
      #1;
      i_reset = 1'b0;
      for (int k = 0; k < 8; k++) rchk(adr[k], 8'h00);
      $display("test reset done");
      for (int k = 0; k < 8; k++) host.wr(adr[k], 8'hff);
      for (int k = 0; k < 8; k++) rchk(adr[k], msk[k]);
      wrs(8'h56, 8'hff);
      chk(o_divider_ratio, 30'h300fffff);
      chk(o_delay, {6'h3f, 3'h4, 8'd120});
      $display("test access done");
      host.wr(8'h52, 8'h34);
      host.wr(8'h51, 8'h12);
      host.wr(8'h50, 8'h05);
      chk(o_divider_update, 1'b0);
      wrs(8'h56, 8'h00);
      chk(o_divider_ratio, 30'h300fffff);
      host.wr(8'h57, 8'h40);
      chk(o_divider_update, 1'b1);
      wrs(8'h56, 8'h00);
      chk(o_divider_ratio, 30'h10051234);
      wrs(8'h54, 8'hc5);
      chk(o_delay, {6'h05, 3'h3, 8'd90});
      $display("test divider delay done");
      for (int k = 0; k < 8; k++) begin
         wrs(8'h55, {3'h0, 2'(k % 3), 3'(k)});
         chk(o_driver_standard, k);
         chk(o_driver_invalid, k > 5);
         chk(o_output_supply_select, k % 3);
      end
      $display("test driver done");
      for (int k = 0; k < 7; k++) begin
         wrs(8'h57, {4'h0, pm[k]});
         chk(o_pin_ctrl, pe[k]);
      end
      $display("test pin mode done");
      wrs(8'h53, 8'h47);
      chk(o_se_strength, 3'h7);
      chk(o_phase_select, 2'h1);
      $display("test strength done");
      summarize();
   end
endmodule // tb
`default_nettype wire
